// File: rtl/iox_map.svh
// Named offsets, reset values, codes and timing counts of the I/O expander.
`ifndef IOX_MAP_SVH
`define IOX_MAP_SVH

// ----------------------------------------------------------------------
// Bus addressing and link framing
// ----------------------------------------------------------------------
`define IOX_ADDR_BASE 7'h74
`define IOX_GCALL_ADDR 8'h00
`define IOX_GCALL_READ 8'h01
`define IOX_SWRST_BYTE 8'h06
`define IOX_BIT_FIRST 4'h0
`define IOX_BIT_LAST 4'h7
`define IOX_BIT_ACK 4'h8
`define IOX_BIT_TOP 3'h7

// ----------------------------------------------------------------------
// Command byte codes
// ----------------------------------------------------------------------
`define IOX_CMD_IN0 8'h00
`define IOX_CMD_IN1 8'h01
`define IOX_CMD_OUT0 8'h02
`define IOX_CMD_OUT1 8'h03
`define IOX_CMD_CFG0 8'h06
`define IOX_CMD_CFG1 8'h07
`define IOX_CMD_DRV0 8'h40
`define IOX_CMD_DRV1 8'h41
`define IOX_CMD_DRV2 8'h42
`define IOX_CMD_DRV3 8'h43
`define IOX_CMD_MASK0 8'h4A
`define IOX_CMD_MASK1 8'h4B
`define IOX_CMD_STAT0 8'h4C
`define IOX_CMD_STAT1 8'h4D

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOX_OUT_RST 16'hFFFF
`define IOX_CFG_RST 16'hFFFF
`define IOX_DRV_RST 32'hFFFFFFFF
`define IOX_MASK_RST 16'hFFFF
`define IOX_PTR_RST 8'h00
`define IOX_BYTE_ZERO 8'h00

// ----------------------------------------------------------------------
// Driver finger enables per drive strength code
// ----------------------------------------------------------------------
`define IOX_FING_C00 4'h1
`define IOX_FING_C01 4'h7
`define IOX_FING_C10 4'h3
`define IOX_FING_C11 4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOX_MCLK_NS 50
`define IOX_IRQ_VALID_NS 1000
`define IOX_IRQ_VALID_CYC ((`IOX_IRQ_VALID_NS) / (`IOX_MCLK_NS))

`endif

// File: rtl/iox_pkg.sv
// Types shared by the I/O expander design.
package iox_pkg;
  typedef logic [15:0] iox_pins_t;
  typedef logic [63:0] iox_fing_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b011,
    ST_GCALL = 3'b100,
    ST_SKIP = 3'b101
  } iox_link_state_t;
endpackage

// File: rtl/iox_sync.sv
// Two flip-flop synchroniser bank for levels entering a clock domain.
module iox_sync #(
  parameter int WIDTH = 1
) (
  input logic clk,
  input logic rst,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import iox_pkg::*;

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: rtl/iox_expander.sv
// Sixteen pin I/O expander core with a two-wire responder link.
`include "iox_map.svh"

// Operation
// - Input-mode pin turns off both high and low side drivers.
// - Output-mode pin drives high or low side per output port bit.
// - Two-bit drive code per pin selects fingers; code 10b enables two.
// - Any edge on an unmasked input-mode pin raises the interrupt.
// - Interrupt clears when pin returns or its port is read.
// - Read clearing happens at the acknowledge bit after the clock rises.
// - Other devices' traffic and output-mode pins never touch the interrupt.
// - Output-to-input change may raise a spurious interrupt by mismatch.
// - Low hardware reset holds registers and link machine at defaults.
// - Hardware reset refreshes the input port register from the pins.
// - General call with write bit is acknowledged, with read bit not.
// - Only data byte 0x06 after general call is acknowledged and arms reset.
// - Further general call bytes are refused and the message discarded.
// - Software reset fires only on STOP; repeated START cancels it.
// - Software reset restores defaults and refreshes the input port register.
// - Power-on reset holds the device; release initialises everything.
// - Matching address is acknowledged by holding SDA low during ack.
// - SDA change while SCL high is decoded as START or STOP.
// - Each byte has one ack bit; device acknowledges every byte of a write to its own address.
// - Controller NACK ends a read; device then releases SDA.
// - Responder address is 0x74 to 0x77 from the two select pins.
// - Last address bit one means read, zero means write.
// - Reads keep using the register chosen by the last command byte.
// - Command pointer defaults to zero after any reset.
module iox_expander (
  input logic mclk,
  input logic rst,
  input logic hw_reset_n,
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input logic addr_sel_lo,
  input logic addr_sel_hi,
  input iox_pkg::iox_pins_t pin_in,
  output iox_pkg::iox_pins_t high_side_fet,
  output iox_pkg::iox_pins_t low_side_fet,
  output iox_pkg::iox_fing_t drive_finger,
  output logic int_o,
  output logic int_oe_n
);
  import iox_pkg::*;

  localparam int IRQ_CYC = `IOX_IRQ_VALID_CYC;
  localparam logic [6:0] ADDR_BASE = `IOX_ADDR_BASE;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  iox_pins_t pin_s;
  iox_pins_t in_reg;
  iox_pins_t out_reg;
  iox_pins_t cfg;
  iox_pins_t mask;
  iox_pins_t pending;
  logic [31:0] drv;
  logic [7:0] ptr;
  logic [7:0] tx_byte;
  logic [5:0] evt_s;
  logic [3:0] evt_d;
  logic [3:0] ev;
  logic swrst;
  logic link_rst;
  logic hold;
  logic dflt;
  logic link_arst;
  logic start_tog;
  logic stop_tog;
  logic start_seen;
  logic snap_tog;
  logic wr_tog;
  logic rdack_tog;
  logic start_new;
  logic [1:0] adr_s;
  iox_link_state_t state;
  iox_link_state_t pend_state;
  logic [3:0] bitcnt;
  logic [6:0] shift;
  logic [7:0] byte_in;
  logic ack_pend;
  logic first_byte;
  logic gc_arm;
  logic [7:0] rd_hold;
  logic [7:0] wr_data;
  logic wr_first;
  logic addr_hit;
  logic bit_step;

  assign link_arst = rst | link_rst;
  assign byte_in = {shift, sda_i};
  assign start_new = start_tog != start_seen;
  assign bit_step = !start_new && state != ST_IDLE && state != ST_SKIP;
  assign addr_hit = byte_in[7:1] == {ADDR_BASE[6:2], adr_s};
  assign pending = (pin_s ^ in_reg) & cfg & ~mask;
  assign ev = evt_s[3:0] ^ evt_d;
  assign hold = !evt_s[5];
  assign dflt = hold | swrst;

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  iox_sync #(.WIDTH(16)) u_pin_sync (
    .clk(mclk),
    .rst(rst),
    .d(pin_in),
    .q(pin_s)
  );

  iox_sync #(.WIDTH(6)) u_evt_sync (
    .clk(mclk),
    .rst(rst),
    .d({hw_reset_n, gc_arm, stop_tog, rdack_tog, wr_tog, snap_tog}),
    .q(evt_s)
  );

  iox_sync #(.WIDTH(2)) u_adr_sync (
    .clk(scl_i),
    .rst(link_arst),
    .d({addr_sel_hi, addr_sel_lo}),
    .q(adr_s)
  );

  // --------------------------------------------------------------------
  // Start and stop detection on SDA edges while SCL is high
  // --------------------------------------------------------------------
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_tog <= 1'b0;
    end else if (scl_i) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_i or posedge rst) begin
    if (rst) begin
      stop_tog <= 1'b0;
    end else if (scl_i) begin
      stop_tog <= ~stop_tog;
    end
  end

  // --------------------------------------------------------------------
  // Link event toggles, reset only at power-on so the far side stays aligned
  // --------------------------------------------------------------------
  always_ff @(posedge scl_i or posedge rst) begin
    if (rst) begin
      start_seen <= 1'b0;
      snap_tog <= 1'b0;
      wr_tog <= 1'b0;
      rdack_tog <= 1'b0;
    end else begin
      start_seen <= start_tog;
      if (start_new || (bit_step && state == ST_READ && bitcnt == `IOX_BIT_FIRST)) begin
        snap_tog <= ~snap_tog;
      end
      if (bit_step && state == ST_WRITE && bitcnt == `IOX_BIT_LAST) begin
        wr_tog <= ~wr_tog;
      end
      if (bit_step && state == ST_READ && bitcnt == `IOX_BIT_ACK) begin
        rdack_tog <= ~rdack_tog;
      end
    end
  end

  // --------------------------------------------------------------------
  // Link byte engine on SCL rising edges
  // --------------------------------------------------------------------
  always_ff @(posedge scl_i or posedge link_arst) begin
    if (link_arst) begin
      state <= ST_IDLE;
      pend_state <= ST_IDLE;
      bitcnt <= `IOX_BIT_FIRST;
      shift <= '0;
      ack_pend <= 1'b0;
      first_byte <= 1'b0;
      gc_arm <= 1'b0;
      rd_hold <= `IOX_BYTE_ZERO;
      wr_data <= `IOX_BYTE_ZERO;
      wr_first <= 1'b0;
    end else if (start_new) begin
      state <= ST_ADDR;
      bitcnt <= `IOX_BIT_FIRST + 4'h1;
      shift <= {6'h00, sda_i};
      ack_pend <= 1'b0;
      first_byte <= 1'b1;
      gc_arm <= 1'b0;
    end else if (bit_step) begin
      if (bitcnt == `IOX_BIT_LAST) begin
        bitcnt <= `IOX_BIT_ACK;
        case (state)
          ST_ADDR: begin
            if (addr_hit) begin
              ack_pend <= 1'b1;
              pend_state <= sda_i ? ST_READ : ST_WRITE;
            end else if (byte_in == `IOX_GCALL_ADDR) begin
              ack_pend <= 1'b1;
              pend_state <= ST_GCALL;
            end else begin
              ack_pend <= 1'b0;
              pend_state <= ST_SKIP;
            end
          end
          ST_WRITE: begin
            ack_pend <= 1'b1;
            pend_state <= ST_WRITE;
            wr_data <= byte_in;
            wr_first <= first_byte;
            first_byte <= 1'b0;
          end
          ST_GCALL: begin
            if (first_byte && byte_in == `IOX_SWRST_BYTE) begin
              ack_pend <= 1'b1;
              gc_arm <= 1'b1;
              pend_state <= ST_GCALL;
            end else begin
              ack_pend <= 1'b0;
              gc_arm <= 1'b0;
              pend_state <= ST_SKIP;
            end
            first_byte <= 1'b0;
          end
          default: begin
            ack_pend <= 1'b0;
            pend_state <= ST_READ;
          end
        endcase
      end else if (bitcnt == `IOX_BIT_ACK) begin
        bitcnt <= `IOX_BIT_FIRST;
        ack_pend <= 1'b0;
        if (state == ST_READ) begin
          state <= sda_i ? ST_SKIP : ST_READ;
          rd_hold <= tx_byte;
        end else begin
          state <= pend_state;
          if (pend_state == ST_READ) begin
            rd_hold <= tx_byte;
          end
        end
      end else begin
        shift <= {shift[5:0], sda_i};
        bitcnt <= bitcnt + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // SDA drive on SCL falling edges
  // --------------------------------------------------------------------
  always_ff @(negedge scl_i or posedge link_arst) begin
    if (link_arst) begin
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n <= !((ack_pend && bitcnt == `IOX_BIT_ACK) ||
                    (state == ST_READ && bitcnt < `IOX_BIT_ACK &&
                     !rd_hold[`IOX_BIT_TOP - bitcnt[2:0]]));
    end
  end

  // --------------------------------------------------------------------
  // Reset sequencing in the system clock domain
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evt_d <= 4'h0;
      swrst <= 1'b0;
      link_rst <= 1'b1;
    end else begin
      evt_d <= evt_s[3:0];
      swrst <= ev[3] && evt_s[4];
      link_rst <= hold || swrst;
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_reg <= `IOX_OUT_RST;
      cfg <= `IOX_CFG_RST;
      drv <= `IOX_DRV_RST;
      mask <= `IOX_MASK_RST;
      ptr <= `IOX_PTR_RST;
    end else if (dflt) begin
      out_reg <= `IOX_OUT_RST;
      cfg <= `IOX_CFG_RST;
      drv <= `IOX_DRV_RST;
      mask <= `IOX_MASK_RST;
      ptr <= `IOX_PTR_RST;
    end else if (ev[1]) begin
      if (wr_first) begin
        ptr <= wr_data;
      end else begin
        case (ptr)
          `IOX_CMD_OUT0: out_reg[7:0] <= wr_data;
          `IOX_CMD_OUT1: out_reg[15:8] <= wr_data;
          `IOX_CMD_CFG0: cfg[7:0] <= wr_data;
          `IOX_CMD_CFG1: cfg[15:8] <= wr_data;
          `IOX_CMD_DRV0: drv[7:0] <= wr_data;
          `IOX_CMD_DRV1: drv[15:8] <= wr_data;
          `IOX_CMD_DRV2: drv[23:16] <= wr_data;
          `IOX_CMD_DRV3: drv[31:24] <= wr_data;
          `IOX_CMD_MASK0: mask[7:0] <= wr_data;
          `IOX_CMD_MASK1: mask[15:8] <= wr_data;
          default: ;
        endcase
      end
    end
  end

  // Input port register is refreshed by hardware and software resets and by reads of its port; power-on reset clears it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_reg <= '0;
    end else if (dflt) begin
      in_reg <= pin_s;
    end else if (ev[2] && ptr == `IOX_CMD_IN0) begin
      in_reg[7:0] <= pin_s[7:0];
    end else if (ev[2] && ptr == `IOX_CMD_IN1) begin
      in_reg[15:8] <= pin_s[15:8];
    end
  end

  // --------------------------------------------------------------------
  // Read data snapshot handed to the link
  // --------------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    logic [7:0] r;
    r = `IOX_BYTE_ZERO;
    case (p)
      `IOX_CMD_IN0: r = pin_s[7:0];
      `IOX_CMD_IN1: r = pin_s[15:8];
      `IOX_CMD_OUT0: r = out_reg[7:0];
      `IOX_CMD_OUT1: r = out_reg[15:8];
      `IOX_CMD_CFG0: r = cfg[7:0];
      `IOX_CMD_CFG1: r = cfg[15:8];
      `IOX_CMD_DRV0: r = drv[7:0];
      `IOX_CMD_DRV1: r = drv[15:8];
      `IOX_CMD_DRV2: r = drv[23:16];
      `IOX_CMD_DRV3: r = drv[31:24];
      `IOX_CMD_MASK0: r = mask[7:0];
      `IOX_CMD_MASK1: r = mask[15:8];
      `IOX_CMD_STAT0: r = pending[7:0];
      `IOX_CMD_STAT1: r = pending[15:8];
      default: r = `IOX_BYTE_ZERO;
    endcase
    return r;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_byte <= `IOX_BYTE_ZERO;
    end else if (ev[0]) begin
      tx_byte <= rd_mux(ptr);
    end
  end

  // --------------------------------------------------------------------
  // Interrupt output, open drain
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_oe_n <= 1'b1;
      int_o <= 1'b0;
    end else begin
      int_oe_n <= !(|pending);
      int_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_pin
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        high_side_fet[i] <= 1'b0;
        low_side_fet[i] <= 1'b0;
        drive_finger[4*i+3:4*i] <= 4'h0;
      end else begin
        high_side_fet[i] <= !cfg[i] && out_reg[i];
        low_side_fet[i] <= !cfg[i] && !out_reg[i];
        case (drv[2*i+1:2*i])
          2'h0: drive_finger[4*i+3:4*i] <= `IOX_FING_C00;
          2'h1: drive_finger[4*i+3:4*i] <= `IOX_FING_C01;
          2'h2: drive_finger[4*i+3:4*i] <= `IOX_FING_C10;
          default: drive_finger[4*i+3:4*i] <= `IOX_FING_C11;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_input_hiz: assert property (@(posedge mclk) disable iff (rst)
    ##1 ((high_side_fet | low_side_fet) & $past(cfg)) == 16'h0000)
    else $error("input pin is driven");

  a_output_drive: assert property (@(posedge mclk) disable iff (rst)
    ##1 (high_side_fet ^ low_side_fet) == ~$past(cfg))
    else $error("output pin not driven by exactly one side");

  a_half_drive: assert property (@(posedge mclk) disable iff (rst)
    drv[5:4] == 2'h2 |=> drive_finger[11:8] == `IOX_FING_C10)
    else $error("code 10b does not give two fingers");

  a_irq_raise: assert property (@(posedge mclk) disable iff (rst)
    $rose(|pending) |-> ##[1:IRQ_CYC] !int_oe_n)
    else $error("interrupt late");

  a_irq_hold: assert property (@(posedge mclk) disable iff (rst)
    (|pending) [*2] |-> !int_oe_n)
    else $error("interrupt dropped with mismatch pending");

  a_read_clear: assert property (@(posedge mclk) disable iff (rst)
    ev[2] && !dflt && ptr == 8'h00 |=> in_reg[7:0] == $past(pin_s[7:0]) ##1 int_oe_n || |pending)
    else $error("port read did not refresh input register");

  a_out_no_irq: assert property (@(posedge mclk) disable iff (rst)
    &(~cfg | mask) |=> int_oe_n)
    else $error("output pins raised interrupt");

  a_hw_hold: assert property (@(posedge mclk) disable iff (rst)
    hold |=> cfg == `IOX_CFG_RST && out_reg == `IOX_OUT_RST && ptr == `IOX_PTR_RST && link_rst)
    else $error("hardware reset not holding defaults");

  a_hw_refresh: assert property (@(posedge mclk) disable iff (rst)
    hold |=> in_reg == $past(pin_s))
    else $error("input register not refreshed in reset");

  a_sw_reset: assert property (@(posedge mclk) disable iff (rst)
    ev[3] && evt_s[4] |-> ##2 mask == `IOX_MASK_RST && drv == `IOX_DRV_RST && ptr == `IOX_PTR_RST)
    else $error("software reset did not restore defaults");

  a_addr_ack: assert property (@(posedge scl_i) disable iff (link_arst)
    bit_step && state == ST_ADDR && bitcnt == 4'h7 && addr_hit |=> ack_pend && bitcnt == 4'h8)
    else $error("matching address not acknowledged");

  a_gc_refuse: assert property (@(posedge scl_i) disable iff (link_arst)
    bit_step && state == ST_GCALL && bitcnt == 4'h7 && !first_byte |=> !ack_pend && !gc_arm)
    else $error("extra general call byte accepted");
endmodule

// File: testbench/iox_host_model.sv
// Behavioural two-wire bus controller that drives the expander link.
module iox_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 40;
  // The clock rests high between frames and SDA is released to the pull-up.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic send_start();
    sda_drv = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic send_stop();
    sda_drv = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_drv = 1'b1;
    // Bus free time before any new START.
    #(13*Q);
  endtask
  // SDA changes only in the low phase and is sampled in the middle of the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the I/O expander driven through its two-wire link.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import iox_pkg::*;
  logic mclk, rst, hw_reset_n, addr_sel_lo, addr_sel_hi, scl, sda_drv;
  logic sda_o, sda_oe_n, int_o, int_oe_n, a, b, ok;
  logic [2:0] k;
  logic [7:0] d;
  wire logic sda;
  iox_pins_t pin_in, high_side_fet, low_side_fet;
  iox_fing_t drive_finger;
  int error_cnt, total_checks;
  assign sda = sda_drv & (sda_oe_n | sda_o);
  iox_expander i_dut (.mclk(mclk), .rst(rst), .hw_reset_n(hw_reset_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_sel_lo(addr_sel_lo),
    .addr_sel_hi(addr_sel_hi), .pin_in(pin_in), .high_side_fet(high_side_fet),
    .low_side_fet(low_side_fet), .drive_finger(drive_finger), .int_o(int_o),
    .int_oe_n(int_oe_n));
  iox_host_model i_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ab, input logic [7:0] c, input logic [7:0] v);
    i_host.send_start();
    i_host.wbyte(ab, k[2]);
    i_host.wbyte(c, k[1]);
    i_host.wbyte(v, k[0]);
    i_host.send_stop();
    pause(10);
  endtask
  task automatic rd_now();
    i_host.send_start();
    i_host.wbyte(8'hE9, ok);
    i_host.rbyte(1'b1, d);
    i_host.send_stop();
    pause(10);
  endtask
  task automatic rd(input logic [7:0] c);
    i_host.send_start();
    i_host.wbyte(8'hE8, a);
    i_host.wbyte(c, b);
    rd_now();
    ok = ok & a & b;
  endtask
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_oe_n !== lvl && n < 60) begin
      pause(1);
      n++;
    end
    chk({int_o, int_oe_n}, {1'b0, lvl});
    if (int_oe_n !== lvl) finish_test();
  endtask
  task automatic gcall(input logic [7:0] v);
    i_host.send_start();
    i_host.wbyte(8'h00, a);
    i_host.wbyte(v, b);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hw_reset_n = 1'b1;
    addr_sel_lo = 1'b0;
    addr_sel_hi = 1'b0;
    pin_in = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    pause(10);
    rst = 1'b0;
    pause(10);
    chk({high_side_fet, low_side_fet, 15'h0, int_oe_n}, 48'h1);
    $display("test reset done");
    wr(8'hE8, 8'h06, 8'h00);
    chk(k, 3'h7);
    chk({high_side_fet, low_side_fet}, 32'h00FF_0000);
    wr(8'hE8, 8'h02, 8'h55);
    chk({high_side_fet, low_side_fet}, 32'h0055_00AA);
    rd(8'h02);
    chk({ok, d}, 9'h155);
    wr(8'hE8, 8'h40, 8'h24);
    chk(drive_finger, 64'hFFFF_FFFF_FFFF_1371);
    wr(8'hE0, 8'h02, 8'h00);
    chk({k[2], low_side_fet}, 17'h000AA);
    @(posedge mclk);
    #1 addr_sel_hi = 1'b1;
    pause(10);
    wr(8'hEC, 8'h02, 8'h0F);
    chk({k, high_side_fet}, 19'h7000F);
    wr(8'hE8, 8'h02, 8'h00);
    chk(k[2], 1'b0);
    addr_sel_hi = 1'b0;
    pause(10);
    $display("test port done");
    wr(8'hE8, 8'h4A, 8'h00);
    wr(8'hE8, 8'h4B, 8'h00);
    pin_in = 16'h0001;
    pause(40);
    chk(int_oe_n, 1'b1);
    pin_in = 16'h0101;
    wait_int(1'b0);
    rd(8'h4D);
    chk({ok, d, int_oe_n}, 10'h202);
    wr(8'hEA, 8'h00, 8'h00);
    chk({k[2], int_oe_n}, 2'b00);
    pin_in = 16'h0001;
    wait_int(1'b1);
    pin_in = 16'h0301;
    wait_int(1'b0);
    rd(8'h01);
    chk({ok, d}, 9'h103);
    wait_int(1'b1);
    pin_in = 16'h0303;
    pause(40);
    wr(8'hE8, 8'h06, 8'h02);
    wait_int(1'b0);
    rd(8'h00);
    wait_int(1'b1);
    $display("test interrupt done");
    i_host.send_start();
    i_host.wbyte(8'h01, a);
    i_host.send_stop();
    chk(a, 1'b0);
    gcall(8'h07);
    i_host.send_stop();
    chk({a, b}, 2'b10);
    gcall(8'h06);
    rd_now();
    chk({a, b, high_side_fet}, 18'h3000D);
    gcall(8'h06);
    i_host.wbyte(8'h06, ok);
    i_host.send_stop();
    pause(10);
    chk({ok, high_side_fet}, 17'h0000D);
    gcall(8'h06);
    i_host.send_stop();
    pause(10);
    chk({high_side_fet, low_side_fet}, 32'h0);
    chk(drive_finger, 64'hFFFF_FFFF_FFFF_FFFF);
    rd_now();
    chk({ok, d}, 9'h103);
    $display("test soft reset done");
    wr(8'hE8, 8'h06, 8'h00);
    hw_reset_n = 1'b0;
    pause(10);
    chk({high_side_fet, low_side_fet}, 32'h0);
    pin_in = 16'h00A5;
    pause(4);
    hw_reset_n = 1'b1;
    pause(10);
    rd_now();
    chk({ok, d}, 9'h1A5);
    $display("test hardware reset done");
    finish_test();
  end
endmodule
